/* design/qct_pkg.sv */
package qct_pkg;

	localparam int unsigned QCT_TAGS   = 32;
	localparam int unsigned QCT_TAG_W  = 5;
	localparam int unsigned QCT_ADDR_W = 8;

	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PENDING  = 8'h04;
	localparam logic [7:0] OFS_ISSUE    = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0c;
	localparam logic [7:0] OFS_DONE     = 8'h10;
	localparam logic [7:0] OFS_VEC_BASE = 8'h80;

	localparam int unsigned CTRL_DEPTH_LSB  = 0;
	localparam logic [5:0]  CTRL_DEPTH_RST  = 6'h20;
	localparam int unsigned ISSUE_TAG_LSB   = 0;
	localparam int unsigned ISSUE_WRITE_BIT = 8;

	localparam int unsigned ST_IRQ      = 0;
	localparam int unsigned ST_BUSY     = 1;
	localparam int unsigned ST_TAGERR   = 2;
	localparam int unsigned ST_BUFERR   = 3;
	localparam int unsigned ST_SETUPERR = 4;

	localparam logic        DIR_TO_HOST = 1'b1;

	typedef enum logic [2:0] {
		FR_NONE     = 3'b000,
		FR_REG      = 3'b001,
		FR_SDB      = 3'b010,
		FR_SETUP    = 3'b011,
		FR_ACTIVATE = 3'b100
	} qct_frame_t;

	typedef enum logic [1:0] {
		IS_IDLE = 2'b00,
		IS_SEND = 2'b01,
		IS_WAIT = 2'b10
	} qct_iss_t;

	typedef enum logic [1:0] {
		DM_IDLE = 2'b00,
		DM_LOOK = 2'b01,
		DM_ARM  = 2'b10
	} qct_dma_t;

endpackage

/* design/qct_pending.sv */
`timescale 1ns/1ps
`default_nettype none
module qct_pending
	import qct_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [31:0] set_i,
	input  wire logic [31:0] clr_i,
	output logic      [31:0] mask_o
);

	logic [31:0] mask_q;

	// New issue wins over a completion on the same bit
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			mask_q <= 32'h0;
		else
			mask_q <= (mask_q & ~clr_i) | set_i;
	end

	assign mask_o = mask_q;

endmodule // qct_pending
`default_nettype wire

/* design/qct_vec_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module qct_vec_mem
	import qct_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        wr_i,
	input  wire logic [4:0]  wr_addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic [4:0]  rd_addr_i,
	output logic      [31:0] rd_data_o
);

	logic [31:0] mem_q [QCT_TAGS];
	logic [31:0] rd_q;

	always_ff @(posedge core_clk_i)
	begin
		if (wr_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	always_ff @(posedge core_clk_i)
	begin
		rd_q <= mem_q[rd_addr_i];
	end

	assign rd_data_o = rd_q;

endmodule // qct_vec_mem
`default_nettype wire

/* design/qct_host.sv */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module qct_host
	import qct_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  sw_addr_i,
	input  wire logic [31:0] sw_wdata_i,
	input  wire logic        sw_wr_i,
	input  wire logic        sw_rd_i,
	output logic      [31:0] sw_rdata_o,
	output logic             cmd_valid_o,
	output logic      [4:0]  cmd_tag_o,
	output logic             cmd_write_o,
	input  wire logic        cmd_ready_i,
	input  wire logic        rx_valid_i,
	input  wire qct_frame_t  rx_type_i,
	input  wire logic        rx_busy_i,
	input  wire logic        rx_irq_i,
	input  wire logic [31:0] rx_bits_i,
	input  wire logic [31:0] rx_bufid_lo_i,
	input  wire logic [31:0] rx_bufid_hi_i,
	input  wire logic        rx_auto_i,
	input  wire logic        rx_dir_i,
	input  wire logic [31:0] rx_count_i,
	output logic             dma_start_o,
	output logic      [31:0] dma_prd_ptr_o,
	output logic             dma_dir_o,
	output logic      [31:0] dma_count_o,
	output logic             dma_go_o,
	output logic             irq_o
);

	function automatic logic [31:0] tag_bit(input logic [4:0] tag);
		tag_bit = 32'h1 << tag;
	endfunction

	logic [5:0]  depth_q;
	logic [31:0] pend;
	logic [31:0] done_q;
	logic        irq_q;
	logic        tagerr_q;
	logic        buferr_q;
	logic        setuperr_q;
	logic        busy_q;
	logic [31:0] rdata_q;
	qct_iss_t    iss_q;
	logic        cmd_valid_q;
	logic [4:0]  cmd_tag_q;
	logic        cmd_write_q;
	qct_dma_t    dma_q;
	logic [4:0]  su_tag_q;
	logic        su_auto_q;
	logic        su_dir_q;
	logic [31:0] su_count_q;
	logic        dma_start_q;
	logic [31:0] dma_ptr_q;
	logic        dma_dir_q;
	logic [31:0] dma_count_q;
	logic        dma_go_q;
	logic [31:0] vec_rd;

	logic [4:0]  issue_tag;
	logic        issue_req;
	logic        issue_ok;
	logic        sdb;
	logic [31:0] clr_mask;
	logic        sdb_evt;
	logic        setup;
	logic [4:0]  rx_tag;
	logic        bufid_ok;
	logic        setup_ok;
	logic        reg_clr;
	logic        activate;
	logic        st_wr;
	logic        vec_wr;
	logic [31:0] set_mask;

	assign issue_tag = sw_wdata_i[ISSUE_TAG_LSB +: QCT_TAG_W];
	assign issue_req = sw_wr_i && (sw_addr_i == OFS_ISSUE);
	// Only idle, in range and not already outstanding
	assign issue_ok  = issue_req && (iss_q == IS_IDLE) && !busy_q
		&& ({1'b0, issue_tag} < depth_q) && !pend[issue_tag];
	assign set_mask  = issue_ok ? tag_bit(issue_tag) : 32'h0;
	// Completion accepted in any state of the busy flag
	assign sdb       = rx_valid_i && (rx_type_i == FR_SDB);
	assign clr_mask  = sdb ? rx_bits_i : 32'h0;
	assign sdb_evt   = sdb && rx_irq_i && ((rx_bits_i & pend) != 32'h0);
	assign setup     = rx_valid_i && (rx_type_i == FR_SETUP);
	assign rx_tag    = rx_bufid_lo_i[QCT_TAG_W-1:0];
	assign bufid_ok  = (rx_bufid_lo_i[31:QCT_TAG_W] == 27'h0)
		&& (rx_bufid_hi_i == 32'h0);
	assign setup_ok  = setup && bufid_ok && pend[rx_tag] && (dma_q == DM_IDLE);
	assign reg_clr   = rx_valid_i && (rx_type_i == FR_REG) && !rx_busy_i;
	assign activate  = rx_valid_i && (rx_type_i == FR_ACTIVATE);
	assign st_wr     = sw_wr_i && (sw_addr_i == OFS_STATUS);
	assign vec_wr    = sw_wr_i && sw_addr_i[7];

	qct_pending u_pending (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.set_i      (set_mask),
		.clr_i      (clr_mask),
		.mask_o     (pend)
	);

	qct_vec_mem u_vec (
		.core_clk_i (core_clk_i),
		.wr_i       (vec_wr),
		.wr_addr_i  (sw_addr_i[6:2]),
		.wr_data_i  (sw_wdata_i),
		.rd_addr_i  (rx_tag),
		.rd_data_o  (vec_rd)
	);

	// Queue depth from identification data, programmed by software
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			depth_q <= CTRL_DEPTH_RST;
		else if (sw_wr_i && (sw_addr_i == OFS_CTRL))
			depth_q <= sw_wdata_i[CTRL_DEPTH_LSB +: 6];
	end

	// Completed tags, write one to clear, set wins
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			done_q <= 32'h0;
		else if (sw_wr_i && (sw_addr_i == OFS_DONE))
			done_q <= (done_q & ~sw_wdata_i) | (clr_mask & pend);
		else
			done_q <= done_q | (clr_mask & pend);
	end

	// Sticky interrupt merges completions until software clears it
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			irq_q <= 1'b0;
		else if (sdb_evt)
			irq_q <= 1'b1;
		else if (st_wr && sw_wdata_i[ST_IRQ])
			irq_q <= 1'b0;
	end

	// Error flags, write one to clear, set wins
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			tagerr_q   <= 1'b0;
			buferr_q   <= 1'b0;
			setuperr_q <= 1'b0;
		end
		else
		begin
			tagerr_q   <= (issue_req && !issue_ok)
				|| (tagerr_q && !(st_wr && sw_wdata_i[ST_TAGERR]));
			buferr_q   <= (setup && !bufid_ok)
				|| (buferr_q && !(st_wr && sw_wdata_i[ST_BUFERR]));
			setuperr_q <= (setup && bufid_ok && !setup_ok)
				|| (setuperr_q && !(st_wr && sw_wdata_i[ST_SETUPERR]));
		end
	end

	// Command issue: one command in flight until the drive drops busy
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			iss_q       <= IS_IDLE;
			cmd_valid_q <= 1'b0;
			cmd_tag_q   <= 5'h0;
			cmd_write_q <= 1'b0;
			busy_q      <= 1'b0;
		end
		else
		begin
			case (iss_q)
				IS_IDLE:
				begin
					if (issue_ok)
					begin
						iss_q       <= IS_SEND;
						cmd_valid_q <= 1'b1;
						cmd_tag_q   <= issue_tag;
						cmd_write_q <= sw_wdata_i[ISSUE_WRITE_BIT];
					end
				end
				IS_SEND:
				begin
					if (cmd_ready_i)
					begin
						iss_q       <= IS_WAIT;
						cmd_valid_q <= 1'b0;
						busy_q      <= 1'b1;
					end
				end
				IS_WAIT:
				begin
					if (reg_clr)
					begin
						iss_q  <= IS_IDLE;
						busy_q <= 1'b0;
					end
				end
				default:
				begin
					iss_q       <= IS_IDLE;
					cmd_valid_q <= 1'b0;
					busy_q      <= 1'b0;
				end
			endcase
		end
	end

	// DMA context from setup frame, no interrupt involved
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			dma_q       <= DM_IDLE;
			su_tag_q    <= 5'h0;
			su_auto_q   <= 1'b0;
			su_dir_q    <= 1'b0;
			su_count_q  <= 32'h0;
			dma_start_q <= 1'b0;
			dma_ptr_q   <= 32'h0;
			dma_dir_q   <= 1'b0;
			dma_count_q <= 32'h0;
			dma_go_q    <= 1'b0;
		end
		else
		begin
			dma_start_q <= 1'b0;
			dma_go_q    <= 1'b0;
			case (dma_q)
				DM_IDLE:
				begin
					if (setup_ok)
					begin
						dma_q      <= DM_LOOK;
						su_tag_q   <= rx_tag;
						su_auto_q  <= rx_auto_i;
						su_dir_q   <= rx_dir_i;
						su_count_q <= rx_count_i;
					end
				end
				DM_LOOK:
				begin
					dma_start_q <= 1'b1;
					dma_ptr_q   <= vec_rd;
					dma_dir_q   <= su_dir_q;
					dma_count_q <= su_count_q;
					if (su_dir_q == DIR_TO_HOST || su_auto_q)
					begin
						dma_go_q <= 1'b1;
						dma_q    <= DM_IDLE;
					end
					else
						dma_q <= DM_ARM;
				end
				DM_ARM:
				begin
					if (activate)
					begin
						dma_go_q <= 1'b1;
						dma_q    <= DM_IDLE;
					end
				end
				default: dma_q <= DM_IDLE;
			endcase
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			rdata_q <= 32'h0;
		else if (sw_rd_i)
		begin
			case (sw_addr_i)
				OFS_CTRL:    rdata_q <= {26'h0, depth_q};
				OFS_PENDING: rdata_q <= pend;
				OFS_ISSUE:   rdata_q <= {23'h0, cmd_write_q, 3'h0, cmd_tag_q};
				OFS_STATUS:  rdata_q <= {27'h0, setuperr_q, buferr_q, tagerr_q,
					busy_q, irq_q};
				OFS_DONE:    rdata_q <= done_q;
				default:     rdata_q <= 32'h0;
			endcase
		end
		else
			rdata_q <= 32'h0;
	end

	assign sw_rdata_o    = rdata_q;
	assign cmd_valid_o   = cmd_valid_q;
	assign cmd_tag_o     = cmd_tag_q;
	assign cmd_write_o   = cmd_write_q;
	assign dma_start_o   = dma_start_q;
	assign dma_prd_ptr_o = dma_ptr_q;
	assign dma_dir_o     = dma_dir_q;
	assign dma_count_o   = dma_count_q;
	assign dma_go_o      = dma_go_q;
	assign irq_o         = irq_q;

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	a_pend_reset: assert property (disable iff (1'b0)
		!nrst_i |=> pend == 32'h0)
		else $error("pending mask not zero after reset");
	a_sdb_clear: assert property (sdb && !issue_ok |=>
		(pend & $past(rx_bits_i)) == 32'h0)
		else $error("completion did not clear marked bits");
	a_sdb_keep: assert property (sdb && !issue_ok |=>
		(pend & ~$past(rx_bits_i)) == ($past(pend) & ~$past(rx_bits_i)))
		else $error("completion touched unmarked bits");
	a_set_first: assert property (cmd_valid_o |-> pend[cmd_tag_o])
		else $error("command sent without pending bit");
	a_tag_range: assert property (cmd_valid_o |-> {1'b0, cmd_tag_o} < depth_q)
		else $error("tag beyond queue depth");
	a_busy_hold: assert property (cmd_valid_o |-> !busy_q ##1 (busy_q || cmd_valid_o))
		else $error("command while busy");
	a_setup_quiet: assert property (setup && !sdb_evt && !irq_q |=> !irq_q)
		else $error("setup frame raised interrupt");
	a_irq_done: assert property (sdb_evt |=> irq_q && irq_o)
		else $error("completion did not interrupt");
	a_dma_load: assert property (setup_ok |-> ##2 dma_start_o
		&& dma_count_o == $past(rx_count_i, 2))
		else $error("DMA context not loaded");
	a_auto_go: assert property (dma_start_o && (dma_dir_o == DIR_TO_HOST || su_auto_q)
		|-> dma_go_o)
		else $error("auto start missing");
	a_done_mark: assert property (sdb |=>
		(done_q & $past(rx_bits_i & pend)) == $past(rx_bits_i & pend))
		else $error("completed tag not recorded");

	c_issue: cover property (cmd_valid_o && cmd_ready_i);
	c_multi: cover property (sdb && $countones(rx_bits_i & pend) > 1);
	c_auto: cover property (setup_ok && rx_auto_i && rx_dir_i != DIR_TO_HOST);
	c_activate: cover property (dma_q == DM_ARM && activate);

endmodule // qct_host
`default_nettype wire

/* verification/qct_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qct_drive_model
	import qct_pkg::*;
#(
	parameter int unsigned QUEUE_DEPTH = 16
)
(
	input  wire logic        core_clk_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [4:0]  cmd_tag_i,
	input  wire logic        cmd_write_i,
	output logic             cmd_ready_o,
	output logic             rx_valid_o,
	output var qct_frame_t   rx_type_o,
	output logic             rx_busy_o,
	output logic             rx_irq_o,
	output logic      [31:0] rx_bits_o,
	output logic      [31:0] rx_bufid_lo_o,
	output logic      [31:0] rx_bufid_hi_o,
	output logic             rx_auto_o,
	output logic             rx_dir_o,
	output logic      [31:0] rx_count_o
);
	initial
	begin
		{cmd_ready_o, rx_valid_o, rx_busy_o, rx_irq_o, rx_auto_o, rx_dir_o} = 6'h00;
		rx_type_o = FR_NONE;
		{rx_bits_o, rx_bufid_lo_o, rx_bufid_hi_o, rx_count_o} = {4{32'ha5a5_5a5a}};
	end

	// Takes one command after dly cycles; busy stays until the caller sends a register frame with busy clear
	task automatic accept(input int dly, output logic [4:0] tag, output logic wr);
		int n;
		n = 0;
		while (cmd_valid_i !== 1'b1 && n < 16)
		begin
			@(posedge core_clk_i);
			n++;
		end
		repeat (dly) @(posedge core_clk_i);
		cmd_ready_o <= 1'b1;
		tag = cmd_tag_i;
		wr = cmd_write_i;
		@(posedge core_clk_i);
		cmd_ready_o <= 1'b0;
		@(posedge core_clk_i);
	endtask

	// Sends one frame at any moment, busy or not; fields scrambled once taken
	task automatic send(input qct_frame_t t, input logic busy = 1'b0, input logic irq = 1'b0,
		input logic [31:0] bits = 32'h0, input logic [31:0] lo = 32'h0,
		input logic [31:0] hi = 32'h0, input logic au = 1'b0, input logic dir = 1'b0,
		input logic [31:0] cnt = 32'h0);
		rx_valid_o <= 1'b1;
		rx_type_o <= t;
		rx_busy_o <= busy;
		rx_irq_o <= irq;
		rx_bits_o <= bits;
		rx_bufid_lo_o <= lo;
		rx_bufid_hi_o <= hi;
		rx_auto_o <= au;
		rx_dir_o <= dir;
		rx_count_o <= cnt;
		@(posedge core_clk_i);
		rx_valid_o <= 1'b0;
		rx_type_o <= qct_frame_t'(~t);
		{rx_busy_o, rx_irq_o, rx_auto_o, rx_dir_o} <= ~{busy, irq, au, dir};
		{rx_bits_o, rx_bufid_lo_o, rx_bufid_hi_o, rx_count_o} <= ~{bits, lo, hi, cnt};
		@(posedge core_clk_i);
	endtask
endmodule // qct_drive_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import qct_pkg::*;
;
	localparam int unsigned DEPTH = 16;
	logic        core_clk_i;
	logic        nrst_i;
	logic [7:0]  sw_addr_i;
	logic [31:0] sw_wdata_i, sw_rdata_o, rx_bits_i, rx_bufid_lo_i, rx_bufid_hi_i, rx_count_i;
	logic [31:0] dma_prd_ptr_o, dma_count_o, d, v, cnt, pend, done, sptr, scnt;
	logic        sw_wr_i, sw_rd_i, cmd_valid_o, cmd_write_o, cmd_ready_i, rx_valid_i;
	logic        rx_busy_i, rx_irq_i, rx_auto_i, rx_dir_i, dma_start_o, dma_dir_o, dma_go_o;
	logic        irq_o, irq_q, w, wb, dr, au, sdir, sgo;
	logic [4:0]  cmd_tag_o, t5;
	logic [3:0]  tg, tn;
	logic [3:0]  tags [8];
	logic [31:0] ptr [16];
	logic [15:0] rnd;
	qct_frame_t  rx_type_i;
	int          err_total, checked, cyc, nstart, ngo, nirq, s0, g0;

	qct_host uut (.core_clk_i, .nrst_i, .sw_addr_i, .sw_wdata_i, .sw_wr_i, .sw_rd_i, .sw_rdata_o,
		.cmd_valid_o, .cmd_tag_o, .cmd_write_o, .cmd_ready_i, .rx_valid_i, .rx_type_i, .rx_busy_i,
		.rx_irq_i, .rx_bits_i, .rx_bufid_lo_i, .rx_bufid_hi_i, .rx_auto_i, .rx_dir_i, .rx_count_i,
		.dma_start_o, .dma_prd_ptr_o, .dma_dir_o, .dma_count_o, .dma_go_o, .irq_o);

	qct_drive_model #(.QUEUE_DEPTH(DEPTH)) drv (.core_clk_i, .cmd_valid_i(cmd_valid_o),
		.cmd_tag_i(cmd_tag_o), .cmd_write_i(cmd_write_o), .cmd_ready_o(cmd_ready_i),
		.rx_valid_o(rx_valid_i), .rx_type_o(rx_type_i), .rx_busy_o(rx_busy_i),
		.rx_irq_o(rx_irq_i), .rx_bits_o(rx_bits_i), .rx_bufid_lo_o(rx_bufid_lo_i),
		.rx_bufid_hi_o(rx_bufid_hi_i), .rx_auto_o(rx_auto_i), .rx_dir_o(rx_dir_i),
		.rx_count_o(rx_count_i));

	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// Counts DMA loads, go pulses and interrupt rises, keeping the last load's fields
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		irq_q <= irq_o;
		if (irq_o === 1'b1 && irq_q !== 1'b1)
			nirq <= nirq + 1;
		if (dma_go_o === 1'b1)
			ngo <= ngo + 1;
		if (dma_start_o === 1'b1)
		begin
			nstart <= nstart + 1;
			{sptr, sdir, scnt, sgo} <= {dma_prd_ptr_o, dma_dir_o, dma_count_o, dma_go_o};
		end
		if (cyc == 6000)
		begin
			err_total++;
			end_of_test();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic exp_go(input logic dir, input logic a);
		return (dir == DIR_TO_HOST) || a;
	endfunction

	task automatic rnd32(output logic [31:0] r);
		rnd = lfsr(rnd);
		r[15:0] = rnd;
		rnd = lfsr(rnd);
		r[31:16] = rnd;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		sw_addr_i <= a;
		sw_wdata_i <= dat;
		sw_wr_i <= 1'b1;
		@(posedge core_clk_i);
		sw_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dat);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge core_clk_i);
		sw_rd_i <= 1'b0;
		@(posedge core_clk_i);
		dat = sw_rdata_o;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		{err_total, checked, cyc, nstart, ngo, nirq} = '0;
		{sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i, nrst_i, irq_q} = '0;
		rnd = 16'h39a6;
		pend = 32'h0;
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		rd(OFS_PENDING, d);
		chk(d, 32'h0);
		rd(OFS_CTRL, d);
		chk(d, 32'(CTRL_DEPTH_RST));
		rd(8'h44, d);
		chk(d, 32'h0);
		wr(OFS_CTRL, DEPTH);
		rd(OFS_CTRL, d);
		chk(d, DEPTH);
		// Issue eight commands, first at the top tag, answering at varied speeds
		for (int i = 0; i < 8; i++)
		begin
			rnd32(v);
			tg = (i == 0) ? 4'hf : v[3:0];
			while (pend[tg])
				tg++;
			tags[i] = tg;
			wb = v[20];
			rnd32(ptr[tg]);
			wr(OFS_VEC_BASE | {2'b00, tg, 2'b00}, ptr[tg]);
			wr(OFS_ISSUE, {23'h0, wb, 3'h0, 1'b0, tg});
			pend[tg] = 1'b1;
			rd(OFS_PENDING, d);
			chk(d, pend);
			drv.accept(i % 3, t5, w);
			chk(t5, tg);
			chk(w, wb);
			rd(OFS_ISSUE, d);
			chk(d, {23'h0, wb, 3'h0, 1'b0, tg});
			if (i == 0)
			begin
				wr(OFS_ISSUE, 32'h0);
				rd(OFS_STATUS, d);
				chk(d, (32'h1 << ST_BUSY) | (32'h1 << ST_TAGERR));
				wr(OFS_STATUS, 32'h1d);
				// Register frame that still shows busy must not release the issue path
				drv.send(FR_REG, 1'b1);
				rd(OFS_STATUS, d);
				chk(d, 32'h1 << ST_BUSY);
			end
			drv.send(FR_REG);
			rd(OFS_STATUS, d);
			chk(d, 32'h0);
		end
		// Tag at the depth limit, then a tag already outstanding
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_ISSUE, (k == 0) ? DEPTH : 32'(tags[1]));
			rd(OFS_STATUS, d);
			chk(d, 32'h1 << ST_TAGERR);
			rd(OFS_PENDING, d);
			chk(d, pend);
			wr(OFS_STATUS, 32'h1d);
		end
		// Random setup frames for every outstanding tag
		for (int i = 0; i < 8; i++)
		begin
			tg = tags[i];
			rnd32(v);
			dr = v[0];
			au = (i < 2) ? 1'(i) : v[1];
			rnd32(cnt);
			s0 = nstart;
			g0 = ngo;
			drv.send(FR_SETUP, , , , {28'h0, tg}, , au, dr, cnt);
			repeat (3) @(posedge core_clk_i);
			chk(nstart - s0, 1);
			chk(sptr, ptr[tg]);
			chk(sdir, dr);
			chk(scnt, cnt);
			chk(sgo, exp_go(dr, au));
			if (!exp_go(dr, au))
			begin
				drv.send(FR_ACTIVATE);
				repeat (2) @(posedge core_clk_i);
				chk(ngo - g0, 1);
			end
		end
		chk(nirq, 0);
		s0 = nstart;
		drv.send(FR_SETUP, , , , {28'h0, tags[0]}, 32'h1);
		rd(OFS_STATUS, d);
		chk(d, 32'h1 << ST_BUFERR);
		chk(nstart - s0, 0);
		wr(OFS_STATUS, 32'h1d);
		// Completions while busy: several tags at once, then a close second one
		tn = 4'h0;
		while (pend[tn])
			tn++;
		wr(OFS_ISSUE, {28'h0, tn});
		pend[tn] = 1'b1;
		drv.accept(0, t5, w);
		v = (32'h1 << tags[0]) | (32'h1 << tags[1]) | (32'h1 << tn) | 32'h8000_0000;
		done = v & pend;
		pend = pend & ~v;
		drv.send(FR_SDB, , 1'b1, v);
		done = done | (pend & (32'h1 << tags[2]));
		pend = pend & ~(32'h1 << tags[2]);
		drv.send(FR_SDB, , 1'b1, 32'h1 << tags[2]);
		rd(OFS_PENDING, d);
		chk(d, pend);
		rd(OFS_DONE, d);
		chk(d, done);
		rd(OFS_STATUS, d);
		chk(d, (32'h1 << ST_IRQ) | (32'h1 << ST_BUSY));
		chk(nirq, 1);
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS, d);
		chk(d, 32'h1 << ST_BUSY);
		chk(irq_o, 1'b0);
		drv.send(FR_REG);
		rnd32(v);
		drv.send(FR_SDB, , 1'b0, v | pend);
		rd(OFS_PENDING, d);
		chk(d, 32'h0);
		chk(nirq, 1);
		// Setup naming a tag that is no longer outstanding is refused
		s0 = nstart;
		drv.send(FR_SETUP, , , , {28'h0, tags[3]}, , 1'b1, 1'b1, 32'h40);
		rd(OFS_STATUS, d);
		chk(d, 32'h1 << ST_SETUPERR);
		chk(nstart - s0, 0);
		chk(nirq, 1);
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
